// ---- rtl/psw_ctrl.sv ----
// Power-save and wake-up controller top with Wishbone registers
//
// Overview of operation
// RULE1: Halt flag write one enters halt
// RULE2: Halt gates every clock, state kept
// RULE3: PWM timer frozen in halt, resumes
// RULE4: Halt exits on port L wake or reset
// RULE5: Wake runs 256 tc start-up before clocks
// RULE6: Halt-disable option ignores halt flag
// RULE7: Idle flag write one enters idle
// RULE8: Idle keeps only oscillator and timer
// RULE9: Idle exits on reset, wake, tick
// RULE10: Tick toggle sets pending, enable gates irq
// RULE11: Tick irq served first when enabled
// RULE12: Software adds two no-ops after entry
// RULE13: Enable mask bit per pin allows wake
// RULE14: Edge select one falling, zero rising
// RULE15: Software edge change follows fixed order
// RULE16: Software sets edges before enabling pins
// RULE17: Pending sets on edge, software clears
// RULE18: No halt while enabled and pending
// RULE19: Wake registers read write, reset cleared
// RULE20: CAN falling edge always wakes, no irq
// RULE21: Port L irq needs pin, global, port enable; pin 7 never raises the irq
// RULE22: Port L irq served before resuming
// RULE23: Edge latching independent of gated clocks
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "psw_defs.svh"
module psw_ctrl #(
   parameter bit HALT_DISABLE = 1'b0  // Halt-disable build option
) (
   input  wire logic        clk_i,       // Oscillator-rate clock
   input  wire logic        rst_i,       // Sync reset, high
   input  wire logic        wb_cyc_i,    // Wishbone cycle
   input  wire logic        wb_stb_i,    // Wishbone strobe
   input  wire logic        wb_we_i,     // Wishbone write
   input  wire logic [3:0]  wb_adr_i,    // Word address
   input  wire logic [3:0]  wb_sel_i,    // Byte selects
   input  wire logic [31:0] wb_dat_i,    // Write data
   output logic      [31:0] wb_dat_o,    // Read data
   output logic             wb_ack_o,    // Acknowledge
   input  wire logic [7:0]  portl_i,     // Port L pins
   input  wire logic        can_rx_i,    // CAN comparator out
   output logic             core_clk_en_o, // Core clock gate
   output logic             pwm_clk_en_o,  // PWM timer gate
   output logic             osc_en_o,    // Oscillator enable
   output logic             tc_tick_o,   // Instruction tick
   output logic             portl_irq_o, // Port L irq
   output logic             idle_irq_o   // Idle tick irq
);
   //------------------------------------------------------------
   // Declarations
   //------------------------------------------------------------
   psw_pkg::psw_state_t       state_q;
   psw_pkg::psw_state_t       state_d;
   psw_pkg::psw_ctrl_t        ctrl_q;
   logic [7:0]                wake_enable_mask_q;
   logic [7:0]                wake_edge_select_q;
   logic [7:0]                wake_pending_q;
   logic [7:0]                wake_pending_d;
   logic                      idle_tick_pending_q;
   logic                      idle_tick_pending_d;
   logic [`PSW_IDLE_W-1:0]    idle_timer_q;
   logic [8:0]                start_cnt_q;
   logic [3:0]                div_q;
   logic [8:0]                lvl;
   logic [8:0]                hit;
   logic                      tc;
   logic                      tick;
   logic                      wr;
   logic                      rd_ack;
   logic [7:0]                wdat;
   logic [7:0]                rdat;
   logic                      wake_l;
   logic                      wake;
   logic                      halt_block;
   logic                      go_halt;
   logic                      go_idle;
   logic                      start_done;
   logic                      sleeping;
   logic [7:0]                stat;
   //------------------------------------------------------------
   // Edge capture
   //------------------------------------------------------------
   psw_sync u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pin_i ({can_rx_i, portl_i}),
      .lvl_o (lvl)
   );
   psw_edge u_edge (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .lvl_i  (lvl),
      .fall_i ({1'b1, wake_edge_select_q}),   // RULE14 RULE20
      .hit_o  (hit)
   );
   //------------------------------------------------------------
   // Bus decode
   //------------------------------------------------------------
   function automatic logic hit_adr(input logic [3:0] a,
                                    input logic [3:0] r);
      hit_adr = (a == r);
   endfunction
   // Write lands only at the edge where ack is seen high
   assign wr   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign wdat = wb_dat_i[7:0];
   assign stat = {3'h0, (state_q == psw_pkg::PSW_RUN),
                  (state_q == psw_pkg::PSW_STARTUP),
                  (state_q == psw_pkg::PSW_HALT),
                  (state_q == psw_pkg::PSW_IDLE), idle_tick_pending_q};
   assign rdat =
      hit_adr(wb_adr_i, `PSW_ADR_CTRL)  ? {ctrl_q.halt, ctrl_q.idle, 3'h0,
                         ctrl_q.global_irq_enable, ctrl_q.portl_irq_enable, ctrl_q.idle_tick_irq_enable} :
      hit_adr(wb_adr_i, `PSW_ADR_STAT)  ? stat :
      hit_adr(wb_adr_i, `PSW_ADR_WAKE_ENABLE_MASK)  ? wake_enable_mask_q :         // RULE19
      hit_adr(wb_adr_i, `PSW_ADR_WAKE_EDGE_SELECT) ? wake_edge_select_q :        // RULE19
      hit_adr(wb_adr_i, `PSW_ADR_WAKE_PENDING) ? wake_pending_q :        // RULE19
      `PSW_RST_8;
   assign rd_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   //------------------------------------------------------------
   // Instruction clock and idle timer
   //------------------------------------------------------------
   assign tc         = (div_q == `PSW_TC_DIV);
   assign sleeping   = (state_q == psw_pkg::PSW_HALT);
   assign tick       = tc & ~sleeping &
                       (idle_timer_q[`PSW_TICK_BIT-1:0] == '1);
   assign start_done = (state_q == psw_pkg::PSW_STARTUP) & tc &
                       (start_cnt_q == `PSW_ONE_9);
   //------------------------------------------------------------
   // Wake and entry conditions
   //------------------------------------------------------------
   assign wake_l     = |(wake_enable_mask_q & wake_pending_q);                // RULE13
   assign wake       = wake_l | hit[8];                    // RULE20
   assign halt_block = wake_l | HALT_DISABLE;              // RULE6 RULE18
   assign go_halt    = wr & hit_adr(wb_adr_i, `PSW_ADR_CTRL) &
                       wdat[`PSW_CTRL_HALT] & ~halt_block; // RULE1
   assign go_idle    = wr & hit_adr(wb_adr_i, `PSW_ADR_CTRL) &
                       wdat[`PSW_CTRL_IDLE] & ~go_halt;    // RULE7
   // Set wins over a software clear in the same cycle
   assign wake_pending_d = ((wr & hit_adr(wb_adr_i, `PSW_ADR_WAKE_PENDING)) ? wdat
                     : wake_pending_q) | hit[7:0];                // RULE17 RULE23
   assign idle_tick_pending_d = ((wr & hit_adr(wb_adr_i, `PSW_ADR_STAT)) ?
                     wdat[`PSW_STAT_IDLE_TICK_PENDING] : idle_tick_pending_q) | tick; // RULE10
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         psw_pkg::PSW_RUN: begin
            if (go_halt) begin
               state_d = psw_pkg::PSW_HALT;
            end else if (go_idle) begin
               state_d = psw_pkg::PSW_IDLE;
            end
         end
         psw_pkg::PSW_HALT: begin
            if (wake) begin                                // RULE4
               state_d = psw_pkg::PSW_STARTUP;             // RULE5
            end
         end
         psw_pkg::PSW_IDLE: begin
            if (wake | tick) begin                         // RULE9
               state_d = psw_pkg::PSW_RUN;
            end
         end
         psw_pkg::PSW_STARTUP: begin
            if (start_done) begin
               state_d = psw_pkg::PSW_RUN;
            end
         end
      endcase
   end
   //------------------------------------------------------------
   // Registers
   //------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin                                     // RULE4 RULE9
         state_q      <= psw_pkg::PSW_RUN;
         ctrl_q       <= '0;
         wake_enable_mask_q       <= `PSW_RST_8;                       // RULE19
         wake_edge_select_q      <= `PSW_RST_8;
         wake_pending_q      <= `PSW_RST_8;
         idle_tick_pending_q      <= 1'b0;
         wb_ack_o     <= 1'b0;
         wb_dat_o     <= 32'h0000_0000;
      end else begin
         state_q  <= state_d;
         wake_pending_q  <= wake_pending_d;
         idle_tick_pending_q  <= idle_tick_pending_d;
         wb_ack_o <= rd_ack;
         wb_dat_o <= {24'h00_0000, rdat};
         if (wr & hit_adr(wb_adr_i, `PSW_ADR_CTRL)) begin
            ctrl_q.global_irq_enable  <= wdat[`PSW_CTRL_GIE];
            ctrl_q.portl_irq_enable <= wdat[`PSW_CTRL_PORTL_IRQ_ENABLE];
            ctrl_q.idle_tick_irq_enable <= wdat[`PSW_CTRL_IDLE_TICK_IRQ_ENABLE];
         end
         ctrl_q.halt <= (state_d == psw_pkg::PSW_HALT);
         ctrl_q.idle <= (state_d == psw_pkg::PSW_IDLE);
         if (wr & hit_adr(wb_adr_i, `PSW_ADR_WAKE_ENABLE_MASK)) begin
            wake_enable_mask_q <= wdat;
         end
         if (wr & hit_adr(wb_adr_i, `PSW_ADR_WAKE_EDGE_SELECT)) begin
            wake_edge_select_q <= wdat;
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q        <= 4'h0;
         idle_timer_q <= '0;
         start_cnt_q  <= 9'h000;
      end else begin
         if (sleeping | tc) begin
            div_q <= 4'h0;
         end else begin
            div_q <= div_q + `PSW_ONE_4;
         end
         if (tc & ~sleeping) begin                         // RULE8
            idle_timer_q <= idle_timer_q + `PSW_ONE_13;
         end
         if (state_q == psw_pkg::PSW_HALT) begin
            start_cnt_q <= `PSW_START_LOAD;                // RULE5
         end else if (tc & (start_cnt_q != 9'h000)) begin
            start_cnt_q <= start_cnt_q - `PSW_ONE_9;
         end
      end
   end
   //------------------------------------------------------------
   // Clock gates and interrupt requests
   //------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_clk_en_o <= 1'b1;
         pwm_clk_en_o  <= 1'b1;
         osc_en_o      <= 1'b1;
         tc_tick_o     <= 1'b0;
         portl_irq_o   <= 1'b0;
         idle_irq_o    <= 1'b0;
      end else begin
         core_clk_en_o <= (state_d == psw_pkg::PSW_RUN);   // RULE2 RULE8
         pwm_clk_en_o  <= (state_d == psw_pkg::PSW_RUN);   // RULE3
         osc_en_o      <= (state_d != psw_pkg::PSW_HALT);  // RULE2 RULE5
         tc_tick_o     <= tc & (state_q == psw_pkg::PSW_RUN);
         portl_irq_o   <= |(wake_enable_mask_q[6:0] & wake_pending_q[6:0]) &
                          ctrl_q.global_irq_enable & ctrl_q.portl_irq_enable;        // RULE21 RULE22
         idle_irq_o    <= idle_tick_pending_q & ctrl_q.idle_tick_irq_enable & ctrl_q.global_irq_enable; // RULE10 RULE11
      end
   end
endmodule

// ---- rtl/psw_defs.svh ----
// Constants for the power-save and wake-up controller
`ifndef PSW_DEFS_SVH
`define PSW_DEFS_SVH
`define PSW_ADR_CTRL      4'h0
`define PSW_ADR_STAT      4'h1
`define PSW_ADR_WAKE_ENABLE_MASK      4'h2
`define PSW_ADR_WAKE_EDGE_SELECT     4'h3
`define PSW_ADR_WAKE_PENDING     4'h4
`define PSW_CTRL_HALT     7
`define PSW_CTRL_IDLE     6
`define PSW_CTRL_GIE      2
`define PSW_CTRL_PORTL_IRQ_ENABLE     1
`define PSW_CTRL_IDLE_TICK_IRQ_ENABLE     0
`define PSW_STAT_IDLE_TICK_PENDING    0
`define PSW_STAT_ASLEEP   1
`define PSW_STAT_HALTED   2
`define PSW_STAT_STARTUP  3
`define PSW_STAT_RUNNING  4
`define PSW_START_LOAD    9'h100
`define PSW_TC_DIV        4'h9
`define PSW_TICK_BIT      12
`define PSW_IDLE_W        13
`define PSW_RST_8         8'h00
`define PSW_ONE_9         9'h001
`define PSW_ONE_13        13'h0001
`define PSW_ONE_4         4'h1
`endif

// ---- rtl/psw_edge.sv ----
// Per-pin edge detector with polarity select
`timescale 1ns/1ps
module psw_edge (
   input  wire logic       clk_i,  // Clock
   input  wire logic       rst_i,  // Sync reset
   input  wire logic [8:0] lvl_i,  // Filtered levels
   input  wire logic [8:0] fall_i, // 1 falling, 0 rising
   output logic      [8:0] hit_o   // Edge seen, one cycle
);
   logic [8:0] prev_q;
   logic [8:0] hit_d;
   genvar g;
   generate
      for (g = 0; g < 9; g = g + 1) begin : g_bit
         assign hit_d[g] = fall_i[g] ? (prev_q[g] & ~lvl_i[g])
                                     : (~prev_q[g] & lvl_i[g]);
      end
   endgenerate
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_q <= 9'h1ff;
         hit_o  <= 9'h000;
      end else begin
         prev_q <= lvl_i;
         hit_o  <= hit_d;
      end
   end
endmodule

// ---- rtl/psw_pkg.sv ----
// Types for the power-save and wake-up controller
package psw_pkg;
   typedef enum logic [1:0] {
      PSW_RUN     = 2'b00,
      PSW_HALT    = 2'b01,
      PSW_IDLE    = 2'b10,
      PSW_STARTUP = 2'b11
   } psw_state_t;
   typedef struct packed {
      logic       halt;
      logic       idle;
      logic       global_irq_enable;
      logic       portl_irq_enable;
      logic       idle_tick_irq_enable;
   } psw_ctrl_t;
endpackage

// ---- rtl/psw_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module psw_sync (
   input  wire logic       clk_i,  // Clock
   input  wire logic       rst_i,  // Sync reset
   input  wire logic [8:0] pin_i,  // Async pins
   output logic      [8:0] lvl_o   // Filtered level
);
   logic [8:0] s1_q;
   logic [8:0] s2_q;
   logic [8:0] s3_q;
   logic [8:0] lvl_d;
   genvar g;
   generate
      for (g = 0; g < 9; g = g + 1) begin : g_bit
         assign lvl_d[g] = (s2_q[g] == s3_q[g]) ? s2_q[g] : lvl_o[g];
      end
   endgenerate
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q  <= 9'h1ff;
         s2_q  <= 9'h1ff;
         s3_q  <= 9'h1ff;
         lvl_o <= 9'h1ff;
      end else begin
         s1_q  <= pin_i;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_o <= lvl_d;
      end
   end
endmodule

// ---- testbench/psw_ctrl_props.sv ----
// Port-level checks for the power-save controller
`timescale 1ns/1ps
module psw_ctrl_props (
   input wire logic        clk_i,         // Clock
   input wire logic        rst_i,         // Sync reset
   input wire logic        wb_cyc_i,      // Cycle
   input wire logic        wb_stb_i,      // Strobe
   input wire logic        wb_we_i,       // Write
   input wire logic [3:0]  wb_adr_i,      // Index
   input wire logic [31:0] wb_dat_o,      // Read data
   input wire logic        wb_ack_o,      // Ack
   input wire logic        core_clk_en_o, // Core gate
   input wire logic        pwm_clk_en_o,  // PWM gate
   input wire logic        osc_en_o,      // Oscillator
   input wire logic        tc_tick_o      // Tick
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ------------------------------
   // Start-up length counter
   // ------------------------------
   logic        osc_q;
   logic        wk_q;
   logic [11:0] cnt_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_q <= 1'b1;
         wk_q  <= 1'b0;
         cnt_q <= 12'h000;
      end else begin
         osc_q <= osc_en_o;
         if (osc_en_o && !osc_q) begin
            wk_q  <= 1'b1;
            cnt_q <= 12'h000;
         end else if (core_clk_en_o) begin
            wk_q  <= 1'b0;
         end else begin
            cnt_q <= cnt_q + 12'h001;
         end
      end
   end
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i &&
      wb_adr_i > 4'h4 |-> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_halt_gates: assert property (
      !osc_en_o |-> !core_clk_en_o && !pwm_clk_en_o)
      else $error("clock runs in halt");
   a_pwm_frozen: assert property (pwm_clk_en_o == core_clk_en_o)
      else $error("pwm gate differs from core");
   a_tick_spacing: assert property (tc_tick_o |=> !tc_tick_o [*8])
      else $error("tick too close");
   a_startup_len: assert property ($rose(core_clk_en_o) && wk_q |->
      cnt_q >= 12'h9EC && cnt_q <= 12'hA14)
      else $error("start-up delay wrong");
endmodule

bind psw_ctrl psw_ctrl_props u_props (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .core_clk_en_o,
   .pwm_clk_en_o, .osc_en_o, .tc_tick_o);

// ---- testbench/psw_ctrl_tb.sv ----
// Self-checking bench for the power-save controller
`timescale 1ns/1ps
module psw_ctrl_tb;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0]  wb_adr_i, wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [7:0]  portl_i;
   logic        can_rx_i, core_clk_en_o, pwm_clk_en_o, osc_en_o;
   logic        tc_tick_o, portl_irq_o, idle_irq_o;
   logic [7:0]  q;
   logic        osc_nh;
   int          errors;
   int          n_checks;
   psw_ctrl uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .portl_i,
      .can_rx_i, .core_clk_en_o, .pwm_clk_en_o, .osc_en_o, .tc_tick_o,
      .portl_irq_o, .idle_irq_o);
   psw_wake_src src (.clk_i, .portl_o(portl_i), .can_rx_o(can_rx_i));
   // Halt-disable build on the same bus and pins
   psw_ctrl #(.HALT_DISABLE(1'b1)) uut_nh (.clk_i, .rst_i, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o(),
      .wb_ack_o(), .portl_i, .can_rx_i, .core_clk_en_o(), .pwm_clk_en_o(),
      .osc_en_o(osc_nh), .tc_tick_o(), .portl_irq_o(), .idle_irq_o());
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // ------------------------------
   // Bus and compare tasks
   // ------------------------------
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chkb(input logic g, input logic e);
      chk({7'h00, g}, {7'h00, e});
   endtask
   task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h00_0000, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) chkb(wb_ack_o, 1'b1);
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      chk(q, e);
   endtask
   task automatic wait_hi(input int s, input int lim);
      int n;
      n = 0;
      while ((s == 0 ? osc_en_o : core_clk_en_o) !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   task automatic results();
      if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_i);
      errors++;
      results();
   end
   initial begin
      errors = 0;
      n_checks = 0;
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 4'h0;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0000_0000;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      for (int i = 2; i < 6; i++) rd(i[3:0], 8'h00);
      xfer(1'b1, 4'h2, 8'hA5);
      rd(4'h2, 8'hA5);
      xfer(1'b1, 4'h3, 8'h5A);
      rd(4'h3, 8'h5A);
      xfer(1'b1, 4'h4, 8'h3C);
      rd(4'h4, 8'h3C);
      xfer(1'b1, 4'h7, 8'hFF);
      rd(4'h7, 8'h00);
      xfer(1'b1, 4'h2, 8'h00);
      xfer(1'b1, 4'h3, 8'h02);
      xfer(1'b1, 4'h4, 8'h00);
      src.pin(0, 1'b0, 8);
      src.pin(0, 1'b1, 8);
      src.pin(1, 1'b0, 8);
      src.pin(2, 1'b0, 8);
      rd(4'h4, 8'h03);
      repeat (20) @(posedge clk_i);
      rd(4'h4, 8'h03);
      xfer(1'b1, 4'h4, 8'h00);
      rd(4'h4, 8'h00);
      src.pin(0, 1'b0, 8);
      src.pin(0, 1'b1, 8);
      xfer(1'b1, 4'h2, 8'h01);
      xfer(1'b1, 4'h0, 8'h06);
      repeat (3) @(posedge clk_i);
      chkb(portl_irq_o, 1'b1);
      xfer(1'b1, 4'h0, 8'h02);
      repeat (3) @(posedge clk_i);
      chkb(portl_irq_o, 1'b0);
      xfer(1'b1, 4'h0, 8'h80);
      repeat (4) @(posedge clk_i);
      chkb(osc_en_o, 1'b1);
      xfer(1'b1, 4'h0, 8'h00);
      xfer(1'b1, 4'h4, 8'h00);
      xfer(1'b1, 4'h0, 8'h80);
      repeat (4) @(posedge clk_i);
      chkb(osc_en_o, 1'b0);
      chkb(core_clk_en_o, 1'b0);
      chkb(osc_nh, 1'b1);
      src.pin(0, 1'b0, 8);
      src.pin(0, 1'b1, 8);
      wait_hi(0, 100);
      chkb(osc_en_o, 1'b1);
      repeat (2000) @(posedge clk_i);
      chkb(core_clk_en_o, 1'b0);
      wait_hi(1, 1000);
      chkb(core_clk_en_o, 1'b1);
      xfer(1'b1, 4'h2, 8'h00);
      xfer(1'b1, 4'h4, 8'h00);
      xfer(1'b1, 4'h0, 8'h86);
      repeat (4) @(posedge clk_i);
      chkb(osc_en_o, 1'b0);
      src.can(1'b0, 8);
      wait_hi(1, 3000);
      chkb(core_clk_en_o, 1'b1);
      chkb(portl_irq_o, 1'b0);
      src.can(1'b1, 8);
      xfer(1'b1, 4'h0, 8'h45);
      repeat (4) @(posedge clk_i);
      chkb(core_clk_en_o, 1'b0);
      chkb(osc_en_o, 1'b1);
      wait_hi(1, 45000);
      chkb(core_clk_en_o, 1'b1);
      @(posedge clk_i);
      chkb(idle_irq_o, 1'b1);
      results();
   end
endmodule

// ---- testbench/psw_wake_src.sv ----
// External wake sources: port L pins and CAN comparator
`timescale 1ns/1ps
module psw_wake_src (
   input  wire logic       clk_i,    // Clock
   output logic      [7:0] portl_o,  // Port L pins
   output logic            can_rx_o  // CAN comparator
);
   initial begin
      portl_o  = 8'hFF;
      can_rx_o = 1'b1;
   end
   task automatic pin(input int i, input logic v, input int hold);
      @(posedge clk_i);
      portl_o[i] <= v;
      repeat (hold) @(posedge clk_i);
   endtask
   task automatic can(input logic v, input int hold);
      @(posedge clk_i);
      can_rx_o <= v;
      repeat (hold) @(posedge clk_i);
   endtask
endmodule
